//--- ipd_pkg.sv
// Package of constants and types for the in-position detector.
package ipd_pkg;
  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [3:0] IPD_ADDR_THRESHOLD = 4'h0;
  localparam logic [3:0] IPD_ADDR_COND_SEL = 4'h1;
  localparam logic [3:0] IPD_ADDR_HOLD_TIME = 4'h2;
  localparam logic [3:0] IPD_ADDR_UNIT_SEL = 4'h3;
  localparam logic [3:0] IPD_ADDR_EXP_TWO = 4'h4;
  localparam logic [3:0] IPD_ADDR_EXP_THREE = 4'h5;
  localparam logic [3:0] IPD_ADDR_STATUS = 4'h6;
  localparam logic [3:0] IPD_ADDR_IRQ_STAT = 4'h7;
  localparam logic [3:0] IPD_ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] IPD_ADDR_NET_LIMIT = 4'h9;
  // ****************************************************************
  // Field positions and limits.
  // ****************************************************************
  localparam int IPD_EXP_TWO_DEV_SEL_BIT = 14;
  localparam int IPD_EXP_THREE_CMD_UNIT_BIT = 3;
  localparam logic [21:0] IPD_THRESHOLD_MAX = 22'h200000;
  localparam logic [14:0] IPD_HOLD_MAX = 15'h7530;
  localparam int IPD_IRQ_RISE_BIT = 0;
  localparam int IPD_IRQ_FALL_BIT = 1;
  // ****************************************************************
  // Reset values.
  // ****************************************************************
  localparam logic [21:0] IPD_THRESHOLD_RST = 22'h00000A;
  localparam logic [3:0] IPD_COND_SEL_RST = 4'h0;
  localparam logic [14:0] IPD_HOLD_RST = 15'h0000;
  localparam logic [15:0] IPD_EXP_RST = 16'h0000;
  // ****************************************************************
  // Timing: one millisecond at a 100 MHz clock.
  // ****************************************************************
  localparam int IPD_CLK_MHZ = 100;
  localparam int IPD_TICK_US = 1000;
  localparam int IPD_TICK_CYCLES = IPD_TICK_US * IPD_CLK_MHZ;
  // ****************************************************************
  // Timer phases of the hold and delay modes.
  // ****************************************************************
  typedef enum logic [1:0] {
    IPD_IDLE,
    IPD_HOLDING,
    IPD_DELAYING,
    IPD_JUDGING
  } ipd_phase_e;
endpackage

//--- ipd_ms_tick.sv
// Millisecond tick divider for the in-position detector.
`timescale 1ns/1ns
`default_nettype none
module ipd_ms_tick
  import ipd_pkg::*;
#(
  parameter int TICK_CYCLES = IPD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  output logic tick
);
  logic [16:0] count;
  logic [16:0] next_count;

  // Counts clock cycles and wraps once per tick period.
  always_comb begin
    if (count == 17'(TICK_CYCLES - 1)) begin
      next_count = 17'h00000;
    end else begin
      next_count = count + 17'h00001;
    end
  end

  // Registers the count.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      count <= 17'h00000;
    end else begin
      count <= next_count;
    end
  end

  // The tick is one cycle wide at the end of each period.
  assign tick = (count == 17'(TICK_CYCLES - 1));
endmodule
`default_nettype wire

//--- ipd_in_position_detector.sv
// In-position detector: threshold compare, condition modes, hold/delay.
// What this block does
// RULE1 - Programmable threshold 0..2097152 compared with deviation.
// RULE2 - Threshold units follow unit select setting.
// RULE3 - Expansion two bit 14 picks deviation source.
// RULE4 - Threshold reused as network flag limit.
// RULE5 - Modes 1-5 after filter, 6-10 before.
// RULE6 - Mode 0: deviation at or below threshold.
// RULE7 - Modes 1,6: no command, deviation below threshold.
// RULE8 - Mode 7: adds zero speed, at-or-below compare.
// RULE9 - Modes 3,8: hold output for hold time.
// RULE10 - Modes 4,9: judge after delay since command ended.
// RULE11 - Compare absolute deviation value.
// RULE12 - Hold 0 means until next command.
// RULE13 - Command during delay restarts delay timer.
// RULE14 - Millisecond tick times hold/delay; reset clears.
`timescale 1ns/1ns
`default_nettype none
module ipd_in_position_detector
  import ipd_pkg::*;
#(
  parameter int TICK_CYCLES = IPD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [31:0] dev_cmd_after,
  input wire logic [31:0] dev_cmd_before,
  input wire logic [31:0] dev_encoder,
  input wire logic [31:0] dev_cmd_unit_net,
  input wire logic cmd_present_after,
  input wire logic cmd_present_before,
  input wire logic zero_speed,
  output logic in_position_output,
  output logic net_in_position_flag,
  output logic excess_cmd_units,
  output logic irq
);
  // ****************************************************************
  // Settings registers.
  // ****************************************************************
  logic [21:0] in_position_threshold;
  logic [3:0] in_position_condition_select;
  logic [14:0] hold_or_delay_time;
  logic deviation_unit_select;
  logic [15:0] function_expansion_two;
  logic [15:0] function_expansion_three;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [21:0] next_threshold;
  logic [3:0] next_cond;
  logic [14:0] next_hold;
  logic next_unit;
  logic [15:0] next_exp_two;
  logic [15:0] next_exp_three;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  logic [31:0] next_rdata;

  // ****************************************************************
  // Deviation selection and comparison.
  // ****************************************************************
  logic [31:0] dev_sel;
  logic [31:0] dev_abs;
  logic [31:0] net_abs;
  logic dev_le;
  logic dev_lt;
  logic cmd_present;
  logic tick;

  // Picks the deviation source by unit select and filter position.
  always_comb begin
    if (deviation_unit_select) begin
      dev_sel = dev_encoder; // see RULE2
    end else if (function_expansion_two[IPD_EXP_TWO_DEV_SEL_BIT]) begin
      dev_sel = dev_cmd_before; // see RULE3
    end else begin
      dev_sel = dev_cmd_after; // see RULE3
    end
  end

  // Absolute values so sign never matters in the compare.
  assign dev_abs = dev_sel[31] ? (~dev_sel + 32'h1) : dev_sel; // see RULE11
  assign dev_le = (dev_abs <= {10'h000, in_position_threshold}); // see RULE1
  assign dev_lt = (dev_abs < {10'h000, in_position_threshold}); // see RULE7

  // Network flag uses command units when expansion three bit 3 is set.
  always_comb begin
    if (function_expansion_three[IPD_EXP_THREE_CMD_UNIT_BIT]) begin
      net_abs = dev_cmd_unit_net[31] ? (~dev_cmd_unit_net + 32'h1)
                                      : dev_cmd_unit_net; // see RULE4
    end else begin
      net_abs = dev_abs; // see RULE4
    end
  end

  // Command presence source: after filter for 1-5, before for 6-10.
  assign cmd_present = (in_position_condition_select > 4'h5)
                       ? cmd_present_before
                       : cmd_present_after; // see RULE5

  // The deviation-excess threshold shares the chosen unit.
  assign excess_cmd_units = ~deviation_unit_select; // see RULE2

  // ****************************************************************
  // Hold and delay timing.
  // ****************************************************************
  ipd_ms_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tick(tick)
  ); // see RULE14

  ipd_phase_e phase;
  ipd_phase_e next_phase;
  logic [14:0] ms_count;
  logic [14:0] next_ms_count;
  logic out_q;
  logic next_out;
  logic hold_mode;
  logic delay_mode;
  logic base_ok;

  assign hold_mode = (in_position_condition_select == 4'h3) ||
                     (in_position_condition_select == 4'h8);
  assign delay_mode = (in_position_condition_select == 4'h4) ||
                      (in_position_condition_select == 4'h9);
  assign base_ok = ~cmd_present && dev_le;

  // Next phase, timer and output for every condition mode.
  always_comb begin
    next_phase = phase;
    next_ms_count = ms_count;
    next_out = 1'b0;
    case (in_position_condition_select)
      4'h0: next_out = dev_le; // see RULE6
      4'h1, 4'h6: next_out = ~cmd_present && dev_lt; // see RULE7
      4'h7: next_out = ~cmd_present && zero_speed && dev_le; // see RULE8
      4'h3, 4'h8: begin
        case (phase)
          IPD_HOLDING: begin
            if (cmd_present) begin
              next_phase = IPD_IDLE; // see RULE12
              next_ms_count = 15'h0000;
            end else if (hold_or_delay_time == 15'h0000) begin
              next_out = 1'b1; // see RULE12
            end else if (ms_count >= hold_or_delay_time) begin
              next_phase = IPD_JUDGING; // see RULE9
              next_out = ~cmd_present && dev_lt;
            end else begin
              next_out = 1'b1; // see RULE9
              if (tick) begin
                next_ms_count = ms_count + 15'h0001;
              end
            end
          end
          IPD_JUDGING: begin
            next_out = ~cmd_present && dev_lt; // see RULE9
            if (cmd_present) begin
              next_phase = IPD_IDLE;
            end
          end
          default: begin
            next_ms_count = 15'h0000;
            if (~cmd_present && dev_lt) begin
              next_phase = IPD_HOLDING; // see RULE9
              next_out = 1'b1;
            end else begin
              next_phase = IPD_IDLE;
            end
          end
        endcase
      end
      4'h4, 4'h9: begin
        if (cmd_present) begin
          next_phase = IPD_DELAYING; // see RULE13
          next_ms_count = 15'h0000;
        end else begin
          case (phase)
            IPD_DELAYING: begin
              if (ms_count >= hold_or_delay_time) begin
                next_phase = IPD_JUDGING; // see RULE10
                next_out = base_ok;
              end else if (tick) begin
                next_ms_count = ms_count + 15'h0001; // see RULE10
              end
            end
            IPD_JUDGING: next_out = base_ok; // see RULE10
            default: next_phase = IPD_DELAYING;
          endcase
        end
      end
      default: begin
        next_phase = IPD_IDLE;
        next_ms_count = 15'h0000;
        next_out = base_ok;
      end
    endcase
    if (!hold_mode && !delay_mode) begin
      next_phase = IPD_IDLE;
      next_ms_count = 15'h0000;
    end
  end

  // Registers phase, timer and output; reset clears the timer.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      phase <= IPD_IDLE; // see RULE14
      ms_count <= 15'h0000; // see RULE14
      out_q <= 1'b0;
    end else begin
      phase <= next_phase;
      ms_count <= next_ms_count;
      out_q <= next_out;
    end
  end

  assign in_position_output = out_q;

  // ****************************************************************
  // Network flag.
  // ****************************************************************
  logic net_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      net_q <= 1'b0;
    end else begin
      net_q <= (net_abs <= {10'h000, in_position_threshold}); // see RULE4
    end
  end
  assign net_in_position_flag = net_q;

  // ****************************************************************
  // Register access and interrupts.
  // ****************************************************************
  logic [1:0] events;
  assign events[IPD_IRQ_RISE_BIT] = next_out & ~out_q;
  assign events[IPD_IRQ_FALL_BIT] = ~next_out & out_q;

  // Writes, sticky status with set winning over read-clear, read mux.
  always_comb begin
    next_threshold = in_position_threshold;
    next_cond = in_position_condition_select;
    next_hold = hold_or_delay_time;
    next_unit = deviation_unit_select;
    next_exp_two = function_expansion_two;
    next_exp_three = function_expansion_three;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_rdata = 32'h00000000;
    if (reg_wr) begin
      case (reg_addr)
        IPD_ADDR_THRESHOLD: begin
          if (reg_wdata <= 32'(IPD_THRESHOLD_MAX)) begin
            next_threshold = reg_wdata[21:0]; // see RULE1
          end
        end
        IPD_ADDR_COND_SEL: begin
          if (reg_wdata <= 32'h0000000A) begin
            next_cond = reg_wdata[3:0];
          end
        end
        IPD_ADDR_HOLD_TIME: begin
          if (reg_wdata <= 32'(IPD_HOLD_MAX)) begin
            next_hold = reg_wdata[14:0]; // see RULE12
          end
        end
        IPD_ADDR_UNIT_SEL: next_unit = reg_wdata[0];
        IPD_ADDR_EXP_TWO: next_exp_two = reg_wdata[15:0];
        IPD_ADDR_EXP_THREE: next_exp_three = reg_wdata[15:0];
        IPD_ADDR_IRQ_MASK: next_irq_mask = reg_wdata[1:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        IPD_ADDR_THRESHOLD: next_rdata = {10'h000, in_position_threshold};
        IPD_ADDR_COND_SEL: next_rdata = {28'h0, in_position_condition_select};
        IPD_ADDR_HOLD_TIME: next_rdata = {17'h0, hold_or_delay_time};
        IPD_ADDR_UNIT_SEL: next_rdata = {31'h0, deviation_unit_select};
        IPD_ADDR_EXP_TWO: next_rdata = {16'h0, function_expansion_two};
        IPD_ADDR_EXP_THREE: next_rdata = {16'h0, function_expansion_three};
        IPD_ADDR_STATUS: next_rdata = {28'h0, phase == IPD_JUDGING,
                                       net_q, cmd_present, out_q};
        IPD_ADDR_IRQ_STAT: begin
          next_rdata = {30'h0, irq_stat};
          next_irq_stat = 2'h0;
        end
        IPD_ADDR_IRQ_MASK: next_rdata = {30'h0, irq_mask};
        IPD_ADDR_NET_LIMIT: next_rdata = {10'h000, in_position_threshold};
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_irq_stat = next_irq_stat | events;
  end

  // Registers settings, status and read data.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      in_position_threshold <= IPD_THRESHOLD_RST;
      in_position_condition_select <= IPD_COND_SEL_RST;
      hold_or_delay_time <= IPD_HOLD_RST;
      deviation_unit_select <= 1'b0; // see RULE2
      function_expansion_two <= IPD_EXP_RST;
      function_expansion_three <= IPD_EXP_RST;
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
      reg_rdata <= 32'h00000000;
    end else begin
      in_position_threshold <= next_threshold;
      in_position_condition_select <= next_cond;
      hold_or_delay_time <= next_hold;
      deviation_unit_select <= next_unit;
      function_expansion_two <= next_exp_two;
      function_expansion_three <= next_exp_three;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_rdata;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  assign irq = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

//--- ipd_in_position_detector_asserts.sv
// Checker of the in-position detector ports.
`timescale 1ns/1ns
`default_nettype none
module ipd_in_position_detector_asserts
  import ipd_pkg::*;
#(
  parameter int TICK_CYCLES = IPD_TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] dev_cmd_after,
  input wire logic [31:0] dev_cmd_before,
  input wire logic [31:0] dev_encoder,
  input wire logic [31:0] dev_cmd_unit_net,
  input wire logic cmd_present_after,
  input wire logic cmd_present_before,
  input wire logic zero_speed,
  input wire logic in_position_output,
  input wire logic net_in_position_flag,
  input wire logic excess_cmd_units
);
  // ****************************************************************
  // Shadow settings and expected compares.
  // ****************************************************************
  logic [21:0] thr, next_thr;
  logic [3:0] mode, next_mode, mode_q;
  logic [14:0] hold, next_hold;
  logic unit, ex2, ex3, next_unit, next_ex2, next_ex3;
  logic [31:0] dev, mag, net_src, mag_net;
  logic cmd, le_q, lt_q, cmd_q, zs_q, net_q;
  logic [15:0] up_cnt, quiet_cnt;
  // Selected deviation, its magnitude and the command source.
  assign dev = unit ? dev_encoder : (ex2 ? dev_cmd_before : dev_cmd_after);
  assign mag = dev[31] ? (~dev + 32'h1) : dev;
  assign net_src = ex3 ? dev_cmd_unit_net : dev;
  assign mag_net = net_src[31] ? (~net_src + 32'h1) : net_src;
  assign cmd = (mode > 4'h5) ? cmd_present_before : cmd_present_after;
  // Accepted writes move the shadow; out-of-range values are dropped.
  always_comb begin
    next_thr = thr;
    next_mode = mode;
    next_hold = hold;
    next_unit = unit;
    next_ex2 = ex2;
    next_ex3 = ex3;
    if (reg_wr) begin
      case (reg_addr)
        IPD_ADDR_THRESHOLD: if (reg_wdata <= {10'h000, IPD_THRESHOLD_MAX})
          next_thr = reg_wdata[21:0];
        IPD_ADDR_COND_SEL: if (reg_wdata <= 32'h0000000A)
          next_mode = reg_wdata[3:0];
        IPD_ADDR_HOLD_TIME: if (reg_wdata <= {17'h00000, IPD_HOLD_MAX})
          next_hold = reg_wdata[14:0];
        IPD_ADDR_UNIT_SEL: next_unit = reg_wdata[0];
        IPD_ADDR_EXP_TWO: next_ex2 = reg_wdata[IPD_EXP_TWO_DEV_SEL_BIT];
        IPD_ADDR_EXP_THREE: next_ex3 = reg_wdata[IPD_EXP_THREE_CMD_UNIT_BIT];
        default: ;
      endcase
    end
  end
  // Register the shadow, the compares and two cycle counters.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      thr <= IPD_THRESHOLD_RST;
      mode <= IPD_COND_SEL_RST;
      hold <= IPD_HOLD_RST;
      {unit, ex2, ex3} <= 3'h0;
      mode_q <= 4'h0;
      {le_q, lt_q, cmd_q, zs_q, net_q} <= 5'h00;
      up_cnt <= 16'h0000;
      quiet_cnt <= 16'h0000;
    end else begin
      {thr, mode, hold} <= {next_thr, next_mode, next_hold};
      {unit, ex2, ex3} <= {next_unit, next_ex2, next_ex3};
      mode_q <= mode;
      le_q <= mag <= {10'h000, thr};
      lt_q <= mag < {10'h000, thr};
      cmd_q <= cmd;
      zs_q <= zero_speed;
      net_q <= mag_net <= {10'h000, thr};
      up_cnt <= in_position_output ? up_cnt + 16'h0001 : 16'h0000;
      quiet_cnt <= cmd ? 16'h0000 : quiet_cnt + 16'h0001;
    end
  end
  // ****************************************************************
  // Port assertions.
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Output modes, network flag, unit flag, reads and the two timers.
  chk_mode_zero_le: assert property (
    mode_q == 4'h0 |-> in_position_output == le_q)
    else $error("mode zero output differs from magnitude compare");
  chk_strict_below: assert property (
    (mode_q == 4'h1 || mode_q == 4'h6) |->
      in_position_output == (!cmd_q && lt_q))
    else $error("strict compare mode output is wrong");
  chk_zero_speed: assert property (
    mode_q == 4'h7 |-> in_position_output == (!cmd_q && zs_q && le_q))
    else $error("zero speed mode output is wrong");
  chk_net_flag: assert property (
    net_in_position_flag == net_q)
    else $error("network flag differs from its compare");
  chk_excess_unit: assert property (
    excess_cmd_units == !unit)
    else $error("excess unit flag does not follow unit select");
  chk_thr_read: assert property (
    $past(reg_rd) && $past(reg_addr) == IPD_ADDR_THRESHOLD |->
      reg_rdata == {10'h000, $past(thr)})
    else $error("threshold read data is wrong");
  chk_limit_read: assert property (
    $past(reg_rd) && $past(reg_addr) == IPD_ADDR_NET_LIMIT |->
      reg_rdata == {10'h000, $past(thr)})
    else $error("network limit read differs from threshold");
  chk_hold_min: assert property (
    (mode_q == 4'h3 || mode_q == 4'h8) && $fell(in_position_output) |->
      $past(cmd) || (hold != 15'h0 &&
      int'(up_cnt) >= (int'(hold) - 1) * TICK_CYCLES))
    else $error("hold ended early");
  chk_delay_min: assert property (
    (mode_q == 4'h4 || mode_q == 4'h9) && $rose(in_position_output) &&
      hold != 15'h0 |-> int'(quiet_cnt) >= (int'(hold) - 1) * TICK_CYCLES)
    else $error("judging started before the delay ran out");
endmodule
bind ipd_in_position_detector ipd_in_position_detector_asserts #(
  .TICK_CYCLES(TICK_CYCLES)
) u_ipd_in_position_detector_asserts (
  .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dev_cmd_after(dev_cmd_after),
  .dev_cmd_before(dev_cmd_before), .dev_encoder(dev_encoder),
  .dev_cmd_unit_net(dev_cmd_unit_net),
  .cmd_present_after(cmd_present_after),
  .cmd_present_before(cmd_present_before), .zero_speed(zero_speed),
  .in_position_output(in_position_output),
  .net_in_position_flag(net_in_position_flag),
  .excess_cmd_units(excess_cmd_units)
);
`default_nettype wire

//--- ipd_host_model.sv
// Host model that counts completed positionings.
`timescale 1ns/1ns
`default_nettype none
module ipd_host_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic in_pos,
  output logic [7:0] rise_count
);
  logic seen;
  // Each new in-position level is one finished move.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      seen <= 1'b0;
      rise_count <= 8'h00;
    end else begin
      seen <= in_pos;
      if (in_pos && !seen) begin
        rise_count <= rise_count + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- ipd_in_position_detector_tb.sv
// Testbench of the in-position detector.
`timescale 1ns/1ns
`default_nettype none
module ipd_in_position_detector_tb
  import ipd_pkg::*;
;
  localparam int TICK = 10;
  logic core_clk, rst_b, reg_wr, reg_rd, irq, excess_cmd_units;
  logic cmd_present_after, cmd_present_before, zero_speed;
  logic in_position_output, net_in_position_flag;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, dev_cmd_after, dev_cmd_before, d;
  logic [31:0] dev_encoder, dev_cmd_unit_net;
  logic [7:0] rise_count, rc0;
  int compares, mismatches, cycles;
  // Design and host model.
  ipd_in_position_detector #(
    .TICK_CYCLES(TICK)
  ) u_ipd_in_position_detector (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .dev_cmd_after(dev_cmd_after),
    .dev_cmd_before(dev_cmd_before), .dev_encoder(dev_encoder),
    .dev_cmd_unit_net(dev_cmd_unit_net),
    .cmd_present_after(cmd_present_after),
    .cmd_present_before(cmd_present_before), .zero_speed(zero_speed),
    .in_position_output(in_position_output),
    .net_in_position_flag(net_in_position_flag),
    .excess_cmd_units(excess_cmd_units), .irq(irq)
  );
  ipd_host_model u_ipd_host_model (
    .core_clk(core_clk), .rst_b(rst_b), .in_pos(in_position_output),
    .rise_count(rise_count)
  );
  // ****************************************************************
  // Clock, hang guard and shared tasks.
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // A stuck run counts as a mismatch and ends the test.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Applies deviations and commands, then waits n edges.
  task automatic go(input logic [31:0] v, w, input logic ca, cb,
                    input int n);
    @(posedge core_clk);
    dev_cmd_after <= v;
    dev_cmd_before <= w;
    dev_encoder <= w;
    cmd_present_after <= ca;
    cmd_present_before <= cb;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    {rst_b, reg_wr, reg_rd, zero_speed} = 4'h0;
    {cmd_present_after, cmd_present_before} = 2'b00;
    reg_addr = 4'h0;
    {reg_wdata, dev_cmd_after, dev_cmd_before} = {3{32'h0}};
    {dev_encoder, dev_cmd_unit_net} = {2{32'h0}};
    {compares, mismatches, cycles} = {3{32'sd0}};
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(IPD_ADDR_THRESHOLD, d);
    check(d, 32'h0000000A);
    wr(IPD_ADDR_THRESHOLD, 32'h00200000);
    wr(IPD_ADDR_THRESHOLD, 32'h00200001);
    rd(IPD_ADDR_THRESHOLD, d);
    check(d, 32'h00200000);
    rd(IPD_ADDR_NET_LIMIT, d);
    check(d, 32'h00200000);
    rd(4'hF, d);
    check(d, 32'h0);
    check(excess_cmd_units, 1'b1);
    $display("register test done");
    wr(IPD_ADDR_THRESHOLD, 32'h64);
    go(32'h64, 32'h64, 1'b1, 1'b1, 2);
    check(in_position_output, 1'b1);
    go(32'hFFFFFF9C, 32'hFFFFFF9C, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b1);
    go(32'h65, 32'h65, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b0);
    wr(IPD_ADDR_UNIT_SEL, 32'h1);
    go(32'h1F4, 32'h10, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b1);
    check(excess_cmd_units, 1'b0);
    wr(IPD_ADDR_UNIT_SEL, 32'h0);
    wr(IPD_ADDR_EXP_TWO, 32'h4000);
    go(32'h1F4, 32'h10, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b1);
    wr(IPD_ADDR_EXP_THREE, 32'h8);
    go(32'h1F4, 32'h1F4, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b0);
    check(net_in_position_flag, 1'b1);
    wr(IPD_ADDR_EXP_TWO, 32'h0);
    wr(IPD_ADDR_EXP_THREE, 32'h0);
    $display("mode zero test done");
    wr(IPD_ADDR_COND_SEL, 32'h1);
    go(32'h64, 32'h64, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b0);
    go(32'h63, 32'h63, 1'b1, 1'b0, 2);
    check(in_position_output, 1'b0);
    wr(IPD_ADDR_COND_SEL, 32'h6);
    wr(IPD_ADDR_COND_SEL, 32'hB);
    rd(IPD_ADDR_COND_SEL, d);
    check(d, 32'h6);
    check(in_position_output, 1'b1);
    go(32'h63, 32'h63, 1'b0, 1'b1, 2);
    check(in_position_output, 1'b0);
    wr(IPD_ADDR_COND_SEL, 32'h7);
    go(32'h64, 32'h64, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b0);
    @(posedge core_clk);
    zero_speed <= 1'b1;
    go(32'h64, 32'h64, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b1);
    $display("command mode test done");
    go(32'h10, 32'h10, 1'b1, 1'b1, 2);
    wr(IPD_ADDR_HOLD_TIME, 32'h7531);
    wr(IPD_ADDR_HOLD_TIME, 32'h2);
    rd(IPD_ADDR_HOLD_TIME, d);
    check(d, 32'h2);
    wr(IPD_ADDR_COND_SEL, 32'h3);
    wr(IPD_ADDR_IRQ_MASK, 32'h1);
    rd(IPD_ADDR_IRQ_STAT, d);
    rc0 = rise_count;
    go(32'h10, 32'h10, 1'b0, 1'b0, 2);
    check(in_position_output, 1'b1);
    check(irq, 1'b1);
    rd(IPD_ADDR_IRQ_STAT, d);
    check(d, 32'h1);
    check(irq, 1'b0);
    go(32'h200, 32'h200, 1'b0, 1'b0, 5);
    check(in_position_output, 1'b1);
    go(32'h200, 32'h200, 1'b0, 1'b0, 40);
    check(in_position_output, 1'b0);
    check(irq, 1'b0);
    rd(IPD_ADDR_IRQ_STAT, d);
    check(d, 32'h2);
    wr(IPD_ADDR_HOLD_TIME, 32'h0);
    go(32'h10, 32'h10, 1'b1, 1'b1, 2);
    go(32'h10, 32'h10, 1'b0, 1'b0, 2);
    go(32'h200, 32'h200, 1'b0, 1'b0, 60);
    check(in_position_output, 1'b1);
    go(32'h200, 32'h200, 1'b1, 1'b1, 2);
    check(in_position_output, 1'b0);
    check(rise_count, rc0 + 8'h02);
    $display("hold test done");
    wr(IPD_ADDR_HOLD_TIME, 32'h3);
    wr(IPD_ADDR_COND_SEL, 32'h4);
    go(32'h10, 32'h10, 1'b0, 1'b0, 15);
    check(in_position_output, 1'b0);
    go(32'h10, 32'h10, 1'b1, 1'b1, 1);
    go(32'h10, 32'h10, 1'b0, 1'b0, 15);
    check(in_position_output, 1'b0);
    go(32'h10, 32'h10, 1'b0, 1'b0, 40);
    check(in_position_output, 1'b1);
    rd(IPD_ADDR_STATUS, d);
    check(d[0], 1'b1);
    $display("delay test done");
    @(posedge core_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(in_position_output, 1'b0);
    @(posedge core_clk);
    rst_b <= 1'b1;
    rd(IPD_ADDR_COND_SEL, d);
    check(d, 32'h0);
    $display("reset test done");
    stop_test();
  end
endmodule
`default_nettype wire
